/* File: verilog/line_msg_pkg.sv */
// Package for the line request message engine: codes, register map, carriers.
// Assumes a single 25 MHz clock domain and a 32-bit register port.
package line_msg_pkg;

  // ==========================================================================
  // Line geometry
  localparam int unsigned NUM_LINES = 8;
  localparam int unsigned LINE_W = 3;
  localparam logic [15:0] LINE_COUNT = 16'h0008;

  // ==========================================================================
  // Message type codes
  localparam logic [15:0] MSG_GET_NAMES = 16'h0001;
  localparam logic [15:0] MSG_GET_DIR = 16'h0002;
  localparam logic [15:0] MSG_SET_DIR = 16'h0003;
  localparam logic [15:0] MSG_GET_LEVEL = 16'h0004;
  localparam logic [15:0] MSG_SET_LEVEL = 16'h0005;
  localparam logic [15:0] MSG_SET_TRIG = 16'h0006;

  // ==========================================================================
  // Direction codes
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_OUT = 2'h1;
  localparam logic [1:0] DIR_IN = 2'h2;

  // ==========================================================================
  // Interrupt trigger codes (table only, no trigger logic behind them)
  localparam logic [7:0] TRIG_NONE = 8'h00;
  localparam logic [7:0] TRIG_RISE = 8'h01;
  localparam logic [7:0] TRIG_FALL = 8'h02;
  localparam logic [7:0] TRIG_BOTH = 8'h03;
  localparam logic [7:0] TRIG_HIGH = 8'h04;
  localparam logic [7:0] TRIG_LOW = 8'h08;

  // ==========================================================================
  // Response status codes
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_ERR = 8'h01;

  // ==========================================================================
  // Name block
  localparam int unsigned NAME_PTR_W = 5;
  localparam logic [NAME_PTR_W-1:0] NAME_LAST = 5'h10;
  localparam logic [31:0] NAME_SIZE = 32'h0000_0011;

  // ==========================================================================
  // Register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_REQ_HDR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REQ_VALUE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RESP_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RESP_VALUE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LINE_COUNT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_NAME_SIZE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_NAME_DATA = 8'h1C;

  // Control register fields
  localparam int unsigned CTRL_SUBMIT_BIT = 0;
  localparam int unsigned CTRL_BUSY_BIT = 0;
  localparam int unsigned CTRL_DONE_BIT = 1;
  localparam int unsigned CTRL_DROP_BIT = 2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [15:0] line;
    logic [15:0] kind;
    logic [31:0] value;
  } req_t;

  typedef struct packed {
    logic [7:0] status;
    logic [31:0] value;
  } resp_t;

endpackage : line_msg_pkg

/* File: verilog/line_name_rom.sv */
// Name block memory: zero-terminated line names, one entry per line.
// Assumes the caller presents the address one cycle before it needs the byte.
module line_name_rom (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Read port
  input wire logic [line_msg_pkg::NAME_PTR_W-1:0] addr_i,
  output logic [7:0] data_o
);

  // ==========================================================================
  // Contents
  // Plain 7-bit ASCII, distinct names; unnamed lines hold a lone zero byte
  function automatic logic [7:0] name_byte(input logic [line_msg_pkg::NAME_PTR_W-1:0] a);
    case (a)
      5'h00: name_byte = 8'h4C; // Line 0 "LED0"
      5'h01: name_byte = 8'h45;
      5'h02: name_byte = 8'h44;
      5'h03: name_byte = 8'h30;
      5'h04: name_byte = 8'h00;
      5'h05: name_byte = 8'h00; // Line 1 unnamed
      5'h06: name_byte = 8'h52; // Line 2 "RESET"
      5'h07: name_byte = 8'h45;
      5'h08: name_byte = 8'h53;
      5'h09: name_byte = 8'h45;
      5'h0A: name_byte = 8'h54;
      default: name_byte = 8'h00; // Lines 3 to 7 unnamed, past the end reads zero
    endcase
  endfunction : name_byte

  // Registered read data keeps the register port timing simple
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o <= 8'h00;
    end else begin
      data_o <= name_byte(addr_i);
    end
  end

endmodule : line_name_rom

/* File: verilog/line_msg_engine.sv */
// Request message engine for a set of general-purpose lines.
// Assumes a register master that never issues read and write in one cycle.
// Register map, byte offsets, one 32-bit word per access
// 0x00 request header: line number in the high half, type in the low half
// 0x04 request value
// 0x08 control: write bit 0 to submit; read busy, done and dropped
// 0x0C response status in the low byte
// 0x10 response value
// 0x14 line count, read only
// 0x18 name block size in bytes, read only
// 0x1C name data, one byte per read; each read moves the pointer on, up to the last byte
//
// Timing
// A submit puts the sequencer in execution for one cycle. The response,
// the done flag and the line state change at the edge that ends it, and
// the pins follow one cycle later. A second submit during execution is
// dropped and flagged, since the request fields are frozen then.
// Read data stand for exactly one cycle and are zero otherwise.
// Only one message is ever in flight; the next waits for the driver.
//
// Limitations
// Trigger setup always fails: there is no event path behind it.
// The name block is fixed at build time, so its size is a constant.
// Set level is accepted on any line and used once it turns to output.
// Pin levels are sensed as presented; no synchroniser sits here.
//
// The placing of the registers and the strobed register port were left to the implementer.
module line_msg_engine (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [line_msg_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Line pins
  input wire logic [line_msg_pkg::NUM_LINES-1:0] line_in_i,
  output logic [line_msg_pkg::NUM_LINES-1:0] line_out_o,
  output logic [line_msg_pkg::NUM_LINES-1:0] line_oe_n_o
);

  // ==========================================================================
  // Types and state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DONE = 3'b100
  } state_t;

  // Sequencer, request and response
  state_t state;
  line_msg_pkg::req_t req;
  line_msg_pkg::resp_t resp;
  logic done;
  logic dropped;
  // Per-line configuration
  logic [1:0] dir [line_msg_pkg::NUM_LINES];
  logic [line_msg_pkg::NUM_LINES-1:0] level;
  // Name stream
  logic [line_msg_pkg::NAME_PTR_W-1:0] name_ptr;
  logic [line_msg_pkg::NAME_PTR_W-1:0] next_name_ptr;
  logic [7:0] name_q;
  // Decoded strobes, line select and next response
  logic [line_msg_pkg::LINE_W-1:0] sel;
  logic submit;
  logic name_rd;
  line_msg_pkg::resp_t next_resp;

  // ==========================================================================
  // Helpers
  // Line number is legal only below the reported count
  // Compared on the full field, so high line numbers cannot alias
  function automatic logic line_ok(input logic [15:0] line);
    line_ok = (line < line_msg_pkg::LINE_COUNT);
  endfunction : line_ok

  // Register port address match
  function automatic logic hit(input logic [line_msg_pkg::ADDR_W-1:0] a,
                               input logic [line_msg_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Control word built from the package field positions
  function automatic logic [31:0] ctrl_word(input logic busy, input logic is_done,
                                            input logic is_dropped);
    ctrl_word = 32'h0000_0000;
    ctrl_word[line_msg_pkg::CTRL_BUSY_BIT] = busy;
    ctrl_word[line_msg_pkg::CTRL_DONE_BIT] = is_done;
    ctrl_word[line_msg_pkg::CTRL_DROP_BIT] = is_dropped;
  endfunction : ctrl_word

  // Strobe decode
  // Only a control write with the submit bit set starts a message
  assign submit = wr_i && hit(addr_i, line_msg_pkg::OFS_CTRL)
                  && wdata_i[line_msg_pkg::CTRL_SUBMIT_BIT];
  assign name_rd = rd_i && hit(addr_i, line_msg_pkg::OFS_NAME_DATA);
  // Low bits pick the line; line_ok guards the upper bits
  assign sel = req.line[line_msg_pkg::LINE_W-1:0];

  // ==========================================================================
  // Request fields, held while a message is in flight
  // Writes during a message are ignored so the decoded fields stay stable
  // Line and type share one word, so a single write sets both
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req <= '0;
    end else if (wr_i && state != ST_EXEC) begin
      if (hit(addr_i, line_msg_pkg::OFS_REQ_HDR)) begin
        req.line <= wdata_i[31:16];
        req.kind <= wdata_i[15:0];
      end
      if (hit(addr_i, line_msg_pkg::OFS_REQ_VALUE)) begin
        req.value <= wdata_i;
      end
    end
  end

  // ==========================================================================
  // Sequencer
  // One message at a time, so every line is answered in arrival order
  // Stricter than needed for different lines, but it keeps ordering trivial
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (submit) begin
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_DONE;
        end
        ST_DONE: begin
          if (submit) begin
            state <= ST_EXEC;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Done and dropped flags; a new submit clears done, a busy submit is dropped
  // Set wins over clear when both fall in one cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done <= 1'b0;
      dropped <= 1'b0;
    end else begin
      if (state == ST_EXEC) begin
        done <= 1'b1;
      end else if (submit) begin
        done <= 1'b0;
      end
      if (submit && state == ST_EXEC) begin
        dropped <= 1'b1;
      end else if (submit) begin
        dropped <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Message decode
  // Every path sets both status and value, so no stale field is ever returned
  always_comb begin
    next_resp.status = line_msg_pkg::STATUS_ERR;
    next_resp.value = 32'h0000_0000;
    case (req.kind)
      line_msg_pkg::MSG_GET_NAMES: begin
        // Bytes follow through the name data window
        next_resp.status = line_msg_pkg::STATUS_OK;
      end
      // Direction as stored; a line never set reads none
      line_msg_pkg::MSG_GET_DIR: begin
        if (line_ok(req.line)) begin
          next_resp.status = line_msg_pkg::STATUS_OK;
          next_resp.value = {30'h0000_0000, dir[sel]};
        end
      end
      // Only none, out and in are legal direction codes
      line_msg_pkg::MSG_SET_DIR: begin
        if (line_ok(req.line) && req.value <= {30'h0000_0000, line_msg_pkg::DIR_IN}) begin
          next_resp.status = line_msg_pkg::STATUS_OK;
        end
      end
      // Sensed level comes from the pin input, not the stored level
      line_msg_pkg::MSG_GET_LEVEL: begin
        if (line_ok(req.line)) begin
          next_resp.status = line_msg_pkg::STATUS_OK;
          next_resp.value = {31'h0000_0000, line_in_i[sel]};
        end
      end
      // Stored even on a line that is not driven, so output starts at it
      line_msg_pkg::MSG_SET_LEVEL: begin
        if (line_ok(req.line) && req.value <= 32'h0000_0001) begin
          next_resp.status = line_msg_pkg::STATUS_OK;
        end
      end
      // Trigger setup is not offered here: no event path exists, so it fails
      line_msg_pkg::MSG_SET_TRIG: begin
        next_resp.status = line_msg_pkg::STATUS_ERR;
      end
      // Unknown type codes
      default: begin
        next_resp.status = line_msg_pkg::STATUS_ERR;
      end
    endcase
    // A bad line number overrides whatever the type decoded to
    if (!line_ok(req.line)) begin
      next_resp.status = line_msg_pkg::STATUS_ERR;
      next_resp.value = 32'h0000_0000;
    end
  end

  // Response latched at the end of execution
  // It stands until the next message completes, so it may be read again
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp <= '0;
    end else if (state == ST_EXEC) begin
      resp <= next_resp;
    end
  end

  // ==========================================================================
  // Per-line state
  // Going to none wipes the held level too, so a later output starts low
  // Failed messages leave every line untouched
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < line_msg_pkg::NUM_LINES; i++) begin
        dir[i] <= line_msg_pkg::DIR_NONE;
      end
      level <= '0;
    end else if (state == ST_EXEC && next_resp.status == line_msg_pkg::STATUS_OK) begin
      if (req.kind == line_msg_pkg::MSG_SET_DIR) begin
        dir[sel] <= req.value[1:0];
        if (req.value[1:0] == line_msg_pkg::DIR_NONE) begin
          level[sel] <= 1'b0;
        end
      end
      if (req.kind == line_msg_pkg::MSG_SET_LEVEL) begin
        level[sel] <= req.value[0];
      end
    end
  end

  // Pin drivers; a line drives only while set to output
  // Registered, so the pins never glitch while direction and level change
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_out_o <= '0;
      line_oe_n_o <= '1;
    end else begin
      for (int i = 0; i < line_msg_pkg::NUM_LINES; i++) begin
        line_out_o[i] <= level[i] && (dir[i] == line_msg_pkg::DIR_OUT);
        line_oe_n_o[i] <= (dir[i] != line_msg_pkg::DIR_OUT);
      end
    end
  end

  // ==========================================================================
  // Name stream
  // Pointer restarts on each names message and stops at the last byte
  // Saturating, so reading too far gives zeros, never the block start again
  always_comb begin
    next_name_ptr = name_ptr;
    if (state == ST_EXEC && req.kind == line_msg_pkg::MSG_GET_NAMES) begin
      next_name_ptr = '0;
    end else if (name_rd && name_ptr != line_msg_pkg::NAME_LAST) begin
      next_name_ptr = name_ptr + 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      name_ptr <= '0;
    end else begin
      name_ptr <= next_name_ptr;
    end
  end

  // ROM is addressed with the next pointer so its output matches name_ptr from the first edge after reset
  line_name_rom u_names (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .addr_i(next_name_ptr),
    .data_o(name_q)
  );

  // ==========================================================================
  // Read data, valid in the cycle after the strobe only
  // Reads have no side effect except on the name data window
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        line_msg_pkg::OFS_REQ_HDR: rdata_o <= {req.line, req.kind};
        line_msg_pkg::OFS_REQ_VALUE: rdata_o <= req.value;
        line_msg_pkg::OFS_CTRL: begin
          rdata_o <= ctrl_word(state == ST_EXEC, done, dropped);
        end
        line_msg_pkg::OFS_RESP_STATUS: rdata_o <= {24'h00_0000, resp.status};
        line_msg_pkg::OFS_RESP_VALUE: rdata_o <= resp.value;
        line_msg_pkg::OFS_LINE_COUNT: rdata_o <= {16'h0000, line_msg_pkg::LINE_COUNT};
        line_msg_pkg::OFS_NAME_SIZE: rdata_o <= line_msg_pkg::NAME_SIZE;
        line_msg_pkg::OFS_NAME_DATA: rdata_o <= {24'h00_0000, name_q};
        default: rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule : line_msg_engine

/* File: sim/line_msg_engine_asserts.sv */
// Checker for the line message engine: register port and pin timing.
// Assumes it is bound to line_msg_engine and sees only that module's ports.
module line_msg_engine_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [line_msg_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Line pins
  input wire logic [line_msg_pkg::NUM_LINES-1:0] line_in_i,
  input wire logic [line_msg_pkg::NUM_LINES-1:0] line_out_o,
  input wire logic [line_msg_pkg::NUM_LINES-1:0] line_oe_n_o
);
  // ==========================================================================
  // Decoded strobes
  logic submit;
  logic rd_ctrl;
  assign submit = wr_i && addr_i == line_msg_pkg::OFS_CTRL && wdata_i[0];
  assign rd_ctrl = rd_i && addr_i == line_msg_pkg::OFS_CTRL;

  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ==========================================================================
  // Register port
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_line_count: assert property (rd_i && addr_i == line_msg_pkg::OFS_LINE_COUNT
    |=> rdata_o == {16'h0, line_msg_pkg::LINE_COUNT}) else $error("bad line count");
  a_name_size: assert property (rd_i && addr_i == line_msg_pkg::OFS_NAME_SIZE
    |=> rdata_o == line_msg_pkg::NAME_SIZE && rdata_o != 32'h0) else $error("bad name size");
  a_status_code: assert property (rd_i && addr_i == line_msg_pkg::OFS_RESP_STATUS
    |=> rdata_o == 32'h0 || rdata_o == 32'h1) else $error("status out of range");

  // ==========================================================================
  // Message sequencing: busy during the cycle after a submit, done after it
  a_busy_in_exec: assert property (submit && !$past(submit) ##1 rd_ctrl
    |=> rdata_o[2:0] == 3'h1) else $error("not busy after submit");
  a_done_in_two: assert property (submit && !$past(submit) ##1 !wr_i ##1 rd_ctrl
    |=> rdata_o[2:0] == 3'h2) else $error("not done two cycles after submit");
  a_drop_flagged: assert property (submit && $past(submit) && !$past(submit, 2)
    ##1 rd_ctrl |=> rdata_o[2:0] == 3'h6) else $error("second submit not dropped");

  // ==========================================================================
  // Pins move only as the result of a message, never on their own
  a_out_needs_drive: assert property ((line_out_o & line_oe_n_o) == '0)
    else $error("level driven on an inactive line");
  a_pins_after_msg: assert property ($changed({line_out_o, line_oe_n_o})
    |-> $past(submit, 3)) else $error("pins changed without a message");

  // Main scenarios reached
  c_drop: cover property (submit && $past(submit));
  c_names: cover property (rd_i && addr_i == line_msg_pkg::OFS_NAME_DATA);
  c_driven: cover property (line_oe_n_o != '1);
endmodule : line_msg_engine_asserts

bind line_msg_engine line_msg_engine_asserts u_asserts (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .line_in_i(line_in_i),
  .line_out_o(line_out_o),
  .line_oe_n_o(line_oe_n_o)
);

/* File: sim/line_pin_model.sv */
// Far-side pin model: what the engine's lines are wired to.
// Assumes active-low output enables, low while the engine drives a line.
module line_pin_model (
  // Engine side
  input wire logic [line_msg_pkg::NUM_LINES-1:0] out_i,
  input wire logic [line_msg_pkg::NUM_LINES-1:0] oe_n_i,
  // Outside world
  input wire logic [line_msg_pkg::NUM_LINES-1:0] ext_i,
  output logic [line_msg_pkg::NUM_LINES-1:0] level_o
);
  // A driven line reads back its own level; others follow the outside source
  assign level_o = (~oe_n_i & out_i) | (oe_n_i & ext_i);
endmodule : line_pin_model

/* File: sim/test_gpio_request_message_engine.sv */
// Testbench for the line message engine: register tasks and message sequences.
// Assumes the engine's package and the pin model are compiled first.
module test_gpio_request_message_engine;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] st_ok = line_msg_pkg::STATUS_OK;
  localparam logic [7:0] st_err = line_msg_pkg::STATUS_ERR;
  // Name block: "LED0", none, "RESET", then five unnamed lines
  localparam logic [135:0] names = 136'h4C45443000005245534554000000000000;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [7:0] line_in_i;
  logic [7:0] line_out_o;
  logic [7:0] line_oe_n_o;
  logic [7:0] ext_lvl = 8'h00;
  int miscompares = 0;
  int checked = 0;
  int i;
  line_msg_pkg::req_t bad [5] = '{{16'h0, 16'h7, 32'h0}, {16'h0, 16'h0, 32'h0},
    {16'h8, 16'h1, 32'h0}, {16'h1, 16'h3, 32'h3}, {16'h1, 16'h5, 32'h2}};
  logic [7:0] trg [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08};

  // ==========================================================================
  // Clock, engine and pins
  always #20 clk_i = ~clk_i;
  line_msg_engine dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .line_in_i(line_in_i),
    .line_out_o(line_out_o), .line_oe_n_o(line_oe_n_o));
  line_pin_model pins (.out_i(line_out_o), .oe_n_i(line_oe_n_o), .ext_i(ext_lvl),
    .level_o(line_in_i));

  // ==========================================================================
  // Tasks; wr, rdchk and msg end just after an edge so the next strobe never shares a step
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask : rdchk

  // Post a request, watch it pass through execution, then read the response
  task automatic msg(input logic [15:0] kind, input logic [15:0] line,
      input logic [31:0] val, input logic [7:0] st, input bit vchk, input logic [31:0] exp);
    wr(line_msg_pkg::OFS_REQ_HDR, {line, kind});
    wr(line_msg_pkg::OFS_REQ_VALUE, val);
    wr(line_msg_pkg::OFS_CTRL, 32'h1);
    rdchk(line_msg_pkg::OFS_CTRL, 32'h1);
    rdchk(line_msg_pkg::OFS_CTRL, 32'h2);
    rdchk(line_msg_pkg::OFS_RESP_STATUS, {24'h0, st});
    if (vchk) rdchk(line_msg_pkg::OFS_RESP_VALUE, exp);
  endtask : msg

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    rdchk(line_msg_pkg::OFS_LINE_COUNT, 32'h8);
    rdchk(line_msg_pkg::OFS_NAME_SIZE, 32'h11);
    rdchk(8'hFC, 32'h0);
    // Name block, plus one read past its end
    msg(16'h0001, 16'h0, 32'h0, st_ok, 1'b0, 32'h0);
    for (i = 0; i < 17; i++) begin
      rdchk(line_msg_pkg::OFS_NAME_DATA, {24'h0, names[135-8*i -: 8]});
    end
    rdchk(line_msg_pkg::OFS_NAME_DATA, 32'h0);
    rdchk(line_msg_pkg::OFS_REQ_HDR, 32'h0000_0001);
    // Level first, then output, as a careful driver would
    msg(16'h0005, 16'h2, 32'h1, st_ok, 1'b1, 32'h0);
    msg(16'h0003, 16'h2, 32'h1, st_ok, 1'b1, 32'h0);
    check({24'h0, line_oe_n_o}, 32'hFB);
    check({24'h0, line_out_o}, 32'h04);
    msg(16'h0002, 16'h2, 32'h0, st_ok, 1'b1, 32'h1);
    msg(16'h0004, 16'h2, 32'h0, st_ok, 1'b1, 32'h1);
    // Input line follows the outside level both ways
    msg(16'h0003, 16'h5, 32'h2, st_ok, 1'b1, 32'h0);
    ext_lvl <= 8'h20;
    msg(16'h0002, 16'h5, 32'h0, st_ok, 1'b1, 32'h2);
    msg(16'h0004, 16'h5, 32'h0, st_ok, 1'b1, 32'h1);
    ext_lvl <= 8'hDF;
    msg(16'h0004, 16'h5, 32'h0, st_ok, 1'b1, 32'h0);
    // Direction none forgets the stored level
    msg(16'h0003, 16'h2, 32'h0, st_ok, 1'b1, 32'h0);
    check({24'h0, line_oe_n_o}, 32'hFF);
    msg(16'h0002, 16'h2, 32'h0, st_ok, 1'b1, 32'h0);
    msg(16'h0003, 16'h2, 32'h1, st_ok, 1'b1, 32'h0);
    check({24'h0, line_out_o}, 32'h00);
    // Bad requests and every trigger code are refused
    for (i = 0; i < 5; i++) begin
      msg(bad[i].kind, bad[i].line, bad[i].value, st_err, 1'b1, 32'h0);
    end
    for (i = 0; i < 6; i++) begin
      msg(16'h0006, 16'h1, {24'h0, trg[i]}, st_err, 1'b1, 32'h0);
    end
    // A submit during execution is dropped; the first still completes
    wr(line_msg_pkg::OFS_REQ_HDR, {16'h5, 16'h0002});
    wr(line_msg_pkg::OFS_CTRL, 32'h1);
    wr(line_msg_pkg::OFS_CTRL, 32'h1);
    rdchk(line_msg_pkg::OFS_CTRL, 32'h6);
    rdchk(line_msg_pkg::OFS_RESP_VALUE, 32'h2);
    // Header writes during execution are refused; the value field is kept
    wr(line_msg_pkg::OFS_CTRL, 32'h1);
    wr(line_msg_pkg::OFS_REQ_HDR, {16'h2, 16'h0004});
    rdchk(line_msg_pkg::OFS_REQ_HDR, 32'h0005_0002);
    rdchk(line_msg_pkg::OFS_REQ_VALUE, 32'h0000_0008);
    // Reset in mid-run releases every line
    nrst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check({24'h0, line_oe_n_o}, 32'hFF);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    #1;
    rdchk(line_msg_pkg::OFS_CTRL, 32'h0);
    tally_and_finish;
  end
endmodule : test_gpio_request_message_engine
